/* File: pkg/tcs_pkg.sv */
package tcs_pkg;
  localparam logic [3:0]  REG_CFG      = 4'h0;
  localparam logic [3:0]  REG_BASE     = 4'h4;
  localparam logic [3:0]  REG_STAT     = 4'h8;
  localparam logic [3:0]  REG_PTR      = 4'hC;
  localparam logic [31:0] CFG_RST      = 32'h0000_0008;
  localparam int          CFG_BUF_LO   = 0;
  localparam int          CFG_PRI_LO   = 8;
  localparam int          CFG_MAC_LO   = 16;
  localparam int          STAT_TXEN    = 16;
  localparam int          STAT_BUSY    = 17;
  localparam logic [15:0] CMD_CODE     = 16'h0004;
  localparam logic [31:0] OFS_CODE     = 32'h0000_0000;
  localparam logic [31:0] OFS_WORD     = 32'h0000_0002;
  localparam logic [31:0] OFS_PHI      = 32'h0000_0004;
  localparam logic [31:0] OFS_PLO      = 32'h0000_0006;
  localparam int          B_CMD        = 0;
  localparam int          B_FRM        = 1;
  localparam int          B_ERR        = 2;
  localparam int          B_SIZE       = 8;
  localparam int          B_BUFS       = 9;
  localparam int          B_ODD        = 10;
  localparam int          B_START      = 11;
  localparam int          B_PRI        = 12;
  localparam int          B_MAC        = 13;
  localparam int          B_FMT        = 14;
  localparam logic [15:0] RSV_MASK     = 16'h80F8;
  localparam logic [15:0] MIN_HDR      = 16'h000F;
  localparam logic [3:0]  ATTN_MAX     = 4'h1;
  localparam logic [15:0] W_CMD_DONE   = 16'h0001;
  localparam logic [15:0] W_FRM_DONE   = 16'h0002;

  typedef enum logic [2:0] {
    TCS_IDLE = 3'b000,
    TCS_CODE = 3'b001,
    TCS_WORD = 3'b010,
    TCS_PHI  = 3'b011,
    TCS_PLO  = 3'b100
  } tcs_state_t;
endpackage : tcs_pkg

/* File: hw/tcs_top.sv */
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
module tcs_top (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        cmd_start,
  input  wire logic        halt_req,
  input  wire logic        frame_sent,
  input  wire logic        frame_notify,
  input  wire logic [31:0] frame_last_list,
  input  wire logic        chain_end,
  input  wire logic [31:0] chain_last_list,
  input  wire logic        chk_valid,
  input  wire logic [31:0] chk_first_list,
  input  wire logic [15:0] chk_frame_len,
  input  wire logic [15:0] chk_byte_sum,
  input  wire logic [15:0] chk_route_len,
  input  wire logic [7:0]  chk_buf_count,
  input  wire logic        chk_odd_fwd,
  input  wire logic        chk_start_bad,
  input  wire logic [2:0]  chk_priority,
  input  wire logic        chk_is_mac,
  input  wire logic [3:0]  chk_src_class,
  input  wire logic [3:0]  chk_attn,
  input  wire logic [7:0]  chk_fc,
  output logic             mem_req,
  output logic      [31:0] mem_addr,
  output logic      [15:0] mem_data,
  input  wire logic        mem_ack,
  output logic             host_irq,
  output logic             tx_enable,
  output logic             keep_ctrl_word
);
  typedef struct packed {
    tcs_pkg::tcs_state_t st;
    logic                wb_ack;
    logic [31:0]         wb_dat;
    logic [31:0]         cfg;
    logic [31:0]         base;
    logic                tx_en;
    logic                sent_any;
    logic                frm_pend;
    logic [31:0]         frm_ptr;
    logic                done_pend;
    logic [31:0]         done_ptr;
    logic                err_pend;
    logic [15:0]         err_word;
    logic [31:0]         err_ptr;
    logic [15:0]         cur_word;
    logic [31:0]         cur_ptr;
    logic [15:0]         last_word;
    logic [31:0]         last_ptr;
    logic                mem_req;
    logic [31:0]         mem_addr;
    logic [15:0]         mem_data;
    logic                irq;
    logic                keep;
  } tcs_regs_t;

  tcs_regs_t q;
  tcs_regs_t d;

  function automatic logic [1:0] reg_idx(input logic [3:0] a);
    reg_idx = a[3:2];
  endfunction : reg_idx

  function automatic logic [15:0] err_cause(
    input logic [31:0] cfg,
    input logic [15:0] len,
    input logic [15:0] sum,
    input logic [15:0] rlen,
    input logic [7:0]  bufs,
    input logic        odd,
    input logic        sbad,
    input logic [2:0]  pri,
    input logic        mac,
    input logic [3:0]  cls,
    input logic [3:0]  attn,
    input logic [7:0]  fc
  );
    logic [15:0] w;
    logic [15:0] minl;
    w    = 16'h0000;
    minl = tcs_pkg::MIN_HDR + rlen;
    w[tcs_pkg::B_SIZE]  = (len != sum) || (len == 16'h0000) || (len < minl);
    w[tcs_pkg::B_BUFS]  = bufs > cfg[tcs_pkg::CFG_BUF_LO +: 8];
    w[tcs_pkg::B_ODD]   = odd;
    w[tcs_pkg::B_START] = sbad;
    w[tcs_pkg::B_PRI]   = pri > cfg[tcs_pkg::CFG_PRI_LO +: 3];
    w[tcs_pkg::B_MAC]   = mac && (!cfg[tcs_pkg::CFG_MAC_LO + cls]
                          || cls == 4'h0 || attn > tcs_pkg::ATTN_MAX);
    w[tcs_pkg::B_FMT]   = fc[0];
    w[tcs_pkg::B_ERR]   = |w[tcs_pkg::B_MAC:tcs_pkg::B_SIZE];
    err_cause = w;
  endfunction : err_cause

  logic        wb_hit;
  logic        wb_wr;
  logic [15:0] chk_word;

  always_comb begin
    wb_hit   = wb_cyc_i && wb_stb_i && !q.wb_ack;
    // write lands on the ack edge, the master still holds the request there
    wb_wr    = wb_cyc_i && wb_stb_i && wb_we_i && q.wb_ack && (&wb_sel_i);
    chk_word = err_cause(q.cfg, chk_frame_len, chk_byte_sum, chk_route_len, chk_buf_count, chk_odd_fwd,
                         chk_start_bad, chk_priority, chk_is_mac, chk_src_class, chk_attn, chk_fc);
    d        = q;
    d.wb_ack = wb_hit;
    d.irq    = 1'b0;
    if (wb_wr) begin
      unique case (reg_idx(wb_adr_i))
        reg_idx(tcs_pkg::REG_CFG):  d.cfg  = wb_dat_i;
        reg_idx(tcs_pkg::REG_BASE): d.base = wb_dat_i;
        default: ;
      endcase
    end
    unique case (reg_idx(wb_adr_i))
      reg_idx(tcs_pkg::REG_CFG):  d.wb_dat = q.cfg;
      reg_idx(tcs_pkg::REG_BASE): d.wb_dat = q.base;
      reg_idx(tcs_pkg::REG_STAT): d.wb_dat = {14'h0000, q.st != tcs_pkg::TCS_IDLE, q.tx_en, q.last_word};
      default:                    d.wb_dat = q.last_ptr;
    endcase
    // pick next report; frame status drains before error or done
    unique case (q.st)
      tcs_pkg::TCS_IDLE: begin
        if (q.frm_pend) begin
          d.cur_word = tcs_pkg::W_FRM_DONE;
          d.cur_ptr  = q.frm_ptr;
          d.frm_pend = 1'b0;
        end else if (q.err_pend) begin
          d.cur_word = q.err_word;
          d.cur_ptr  = q.err_ptr;
          d.err_pend = 1'b0;
        end else if (q.done_pend) begin
          d.cur_word = tcs_pkg::W_CMD_DONE;
          d.cur_ptr  = q.done_ptr;
          d.done_pend = 1'b0;
        end
        if (q.frm_pend || q.err_pend || q.done_pend) begin
          d.st       = tcs_pkg::TCS_CODE;
          d.mem_req  = 1'b1;
          d.mem_addr = q.base + tcs_pkg::OFS_CODE;
          d.mem_data = tcs_pkg::CMD_CODE;
        end
      end
      tcs_pkg::TCS_CODE: begin
        if (mem_ack) begin
          d.st       = tcs_pkg::TCS_WORD;
          d.mem_addr = q.base + tcs_pkg::OFS_WORD;
          d.mem_data = q.cur_word & ~tcs_pkg::RSV_MASK;
        end
      end
      tcs_pkg::TCS_WORD: begin
        if (mem_ack) begin
          d.st       = tcs_pkg::TCS_PHI;
          d.mem_addr = q.base + tcs_pkg::OFS_PHI;
          d.mem_data = q.cur_ptr[31:16];
        end
      end
      tcs_pkg::TCS_PHI: begin
        if (mem_ack) begin
          d.st       = tcs_pkg::TCS_PLO;
          d.mem_addr = q.base + tcs_pkg::OFS_PLO;
          d.mem_data = q.cur_ptr[15:0];
        end
      end
      tcs_pkg::TCS_PLO: begin
        if (mem_ack) begin
          // irq only after the last word landed, host never sees a stale block
          d.st        = tcs_pkg::TCS_IDLE;
          d.mem_req   = 1'b0;
          d.irq       = 1'b1;
          d.last_word = q.cur_word & ~tcs_pkg::RSV_MASK;
          d.last_ptr  = q.cur_ptr;
        end
      end
      default: begin
        d.st      = tcs_pkg::TCS_IDLE;
        d.mem_req = 1'b0;
      end
    endcase
    // events after the pick: a set in the same cycle survives the clear
    if (cmd_start) begin
      d.tx_en    = 1'b1;
      d.sent_any = 1'b0;
      d.keep     = 1'b0;
    end
    if (frame_sent && q.tx_en) begin
      d.sent_any = 1'b1;
      d.frm_ptr  = frame_last_list;
      if (frame_notify) begin
        d.frm_pend = 1'b1;
      end
    end
    if (chk_valid && q.tx_en && (chk_word[tcs_pkg::B_ERR] || chk_word[tcs_pkg::B_FMT])) begin
      d.err_pend = 1'b1;
      d.err_word = chk_word;
      d.err_ptr  = chk_first_list;
      d.tx_en    = 1'b0;
      d.keep     = 1'b1;
    end else if (chain_end && q.tx_en) begin
      d.done_pend = 1'b1;
      d.done_ptr  = chain_last_list;
      d.tx_en     = 1'b0;
    end else if (halt_req && q.tx_en) begin
      d.done_pend = 1'b1;
      d.done_ptr  = q.sent_any ? q.frm_ptr : 32'h0000_0000;
      d.tx_en     = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q          <= '0;
      q.st       <= tcs_pkg::TCS_IDLE;
      q.cfg      <= tcs_pkg::CFG_RST;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o       = q.wb_dat;
  assign wb_ack_o       = q.wb_ack;
  assign mem_req        = q.mem_req;
  assign mem_addr       = q.mem_addr;
  assign mem_data       = q.mem_data;
  assign host_irq       = q.irq;
  assign tx_enable      = q.tx_en;
  assign keep_ctrl_word = q.keep;

  sequence word_beat_s;
    q.st == tcs_pkg::TCS_WORD && q.mem_req;
  endsequence

  sequence last_beat_s;
    q.st == tcs_pkg::TCS_PLO && mem_ack;
  endsequence

  sequence code_beat_s;
    q.st == tcs_pkg::TCS_CODE && q.mem_req;
  endsequence

  sequence phi_beat_s;
    q.st == tcs_pkg::TCS_PHI && q.mem_req;
  endsequence

  sequence plo_beat_s;
    q.st == tcs_pkg::TCS_PLO && q.mem_req;
  endsequence

  sequence beat_wait_s;
    q.mem_req && !mem_ack;
  endsequence

  rsv_bits_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    word_beat_s |-> (q.mem_data & tcs_pkg::RSV_MASK) == 16'h0000)
    else $error("reserved bits driven");

  err_word_excl_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    word_beat_s and q.mem_data[tcs_pkg::B_ERR] |-> q.mem_data[1:0] == 2'b00)
    else $error("error word carries done bits");

  irq_after_post_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    last_beat_s |=> q.irq && !q.mem_req && q.last_ptr == $past(q.cur_ptr))
    else $error("irq not after last status word");

  irq_needs_post_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    q.irq |-> $past(q.st) == tcs_pkg::TCS_PLO && $past(mem_ack))
    else $error("irq without posting");

  chain_done_ptr_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    chain_end && q.tx_en && !chk_valid |=> q.done_pend && !q.tx_en && q.done_ptr == $past(chain_last_list))
    else $error("done pointer wrong");

  halt_early_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    halt_req && q.tx_en && !q.sent_any && !chain_end && !chk_valid |=> q.done_pend && q.done_ptr == 32'h0000_0000)
    else $error("early abort pointer not cleared");

  frame_first_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    q.st == tcs_pkg::TCS_IDLE && q.frm_pend && q.err_pend |=> q.cur_word == tcs_pkg::W_FRM_DONE ##1 q.err_pend)
    else $error("error posted before frame status");

  size_err_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    chk_valid && q.tx_en && chk_frame_len == 16'h0000 |=> q.err_pend && q.err_word[tcs_pkg::B_SIZE] && q.keep)
    else $error("zero length not flagged");

  fmt_err_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    chk_valid && q.tx_en && chk_fc[0] |=> q.err_word[tcs_pkg::B_FMT] && !q.tx_en)
    else $error("format error not flagged");

  code_beat_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    code_beat_s |-> q.mem_data == tcs_pkg::CMD_CODE && q.mem_addr == q.base + tcs_pkg::OFS_CODE)
    else $error("code beat wrong");

  ptr_high_beat_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    phi_beat_s |-> q.mem_data == q.cur_ptr[31:16] && q.mem_addr == q.base + tcs_pkg::OFS_PHI)
    else $error("pointer high beat wrong");

  ptr_low_beat_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    plo_beat_s |-> q.mem_data == q.cur_ptr[15:0] && q.mem_addr == q.base + tcs_pkg::OFS_PLO)
    else $error("pointer low beat wrong");

  beat_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    beat_wait_s |=> q.mem_req && $stable(q.mem_addr) && $stable(q.mem_data))
    else $error("status beat changed before ack");

  irq_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    q.irq |=> !q.irq)
    else $error("interrupt longer than one cycle");

  tx_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !q.tx_en && !cmd_start |=> !q.tx_en)
    else $error("transmit resumed without command");

  frame_pend_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    frame_sent && frame_notify && q.tx_en |=> q.frm_pend)
    else $error("notified frame not reported");

  frame_ptr_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    frame_sent && q.tx_en |=> q.frm_ptr == $past(frame_last_list))
    else $error("frame pointer not latest list");

  halt_done_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    halt_req && q.tx_en && !chain_end && !chk_valid |=> q.done_pend && !q.tx_en)
    else $error("abort did not complete command");

  err_stop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    chk_valid && q.tx_en && chk_word[tcs_pkg::B_ERR]
      |=> q.err_pend && !q.tx_en && q.err_ptr == $past(chk_first_list))
    else $error("list error not latched");

  err_word_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    q.err_pend |-> q.err_word[tcs_pkg::B_FRM:tcs_pkg::B_CMD] == 2'h0
      && q.err_word[tcs_pkg::B_ERR] == (|q.err_word[tcs_pkg::B_MAC:tcs_pkg::B_SIZE]))
    else $error("error word flags inconsistent");

  done_word_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    q.st == tcs_pkg::TCS_IDLE && q.done_pend && !q.frm_pend && !q.err_pend
      |=> q.cur_word == tcs_pkg::W_CMD_DONE && q.cur_ptr == $past(q.done_ptr))
    else $error("done report wrong");

  bufs_err_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    chk_valid && q.tx_en && chk_buf_count > q.cfg[tcs_pkg::CFG_BUF_LO +: 8] |=> q.err_word[tcs_pkg::B_BUFS])
    else $error("buffer limit not flagged");
endmodule : tcs_top

/* File: sim/tcs_host_model.sv */
module tcs_host_model (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  input  wire logic [15:0] mem_data,
  output logic             mem_ack,
  output logic [3:0][15:0] blk_q,
  output logic [31:0]      base_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_q;
  // ack stands one cycle; a slow host lets reports pile up behind a post
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mem_ack <= 1'h0;
      wait_q  <= 3'h0;
    end else if (mem_ack) begin
      mem_ack <= 1'h0;
      wait_q  <= slow ? 3'($urandom_range(2, 5)) : 3'h0;
    end else if (mem_req && wait_q == 3'h0) begin
      mem_ack <= 1'h1;
    end else if (mem_req) begin
      wait_q <= wait_q - 3'h1;
    end
  end
  // words land by offset only at the ack edge; base is assumed 8-byte aligned
  always_ff @(posedge core_clk) begin
    if (mem_req && mem_ack) begin
      blk_q[mem_addr[2:1]] <= mem_data;
      if (mem_addr[2:1] == 2'h0) begin
        base_q <= mem_addr;
      end
    end
  end
endmodule : tcs_host_model

/* File: sim/tcs_top_tb.sv */
module tcs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] CFG_V  = 32'h0008_0406; // 6 buffers, priority 4, mac class 3
  localparam logic [31:0] BASE_V = 32'h0000_1000;
  typedef struct packed {
    logic [15:0] len, sum, rlen;
    logic [7:0]  bufs, fc;
    logic        odd, sbad, mac;
    logic [2:0]  pri;
    logic [3:0]  cls, attn;
  } tcs_fld_t;
  logic             core_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, frame_notify, slow;
  logic             mem_req, mem_ack, host_irq, tx_enable, keep_ctrl_word;
  logic [3:0]       wb_adr_i, wb_sel_i;
  logic [4:0]       ev_q;
  logic [15:0]      mem_data;
  logic [31:0]      wb_dat_i, wb_dat_o, mem_addr, base_q, rd, lst;
  logic [3:0][15:0] blk_q;
  tcs_fld_t         fld;
  int               bad_count = 0, check_count = 0, cycles = 0;

  tcs_top tcs_top_i (
    .core_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .cmd_start(ev_q[0]), .halt_req(ev_q[1]), .frame_sent(ev_q[2]), .frame_notify, .frame_last_list(lst),
    .chain_end(ev_q[3]), .chain_last_list(lst), .chk_valid(ev_q[4]), .chk_first_list(lst),
    .chk_frame_len(fld.len), .chk_byte_sum(fld.sum), .chk_route_len(fld.rlen), .chk_buf_count(fld.bufs),
    .chk_odd_fwd(fld.odd), .chk_start_bad(fld.sbad), .chk_priority(fld.pri), .chk_is_mac(fld.mac),
    .chk_src_class(fld.cls), .chk_attn(fld.attn), .chk_fc(fld.fc), .mem_req, .mem_addr, .mem_data,
    .mem_ack, .host_irq, .tx_enable, .keep_ctrl_word
  );
  tcs_host_model tcs_host_model_i (
    .core_clk, .sys_rst, .slow, .mem_req, .mem_addr, .mem_data, .mem_ack, .blk_q, .base_q
  );

  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      bad_count++;
      print_verdict();
    end
  end

  task check(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task wb(input logic we, input logic [3:0] a, input logic [3:0] sel, input logic [31:0] d);
    @(posedge core_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= sel;
    wb_dat_i <= d;
    // no local limit: only the cycle ceiling ends a hung wait
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i  <= 1'h0;
  endtask : wb

  // one pulse; lists share one bus so frame and check may fire together
  task ev(input logic [4:0] m, input logic nt, input logic [31:0] l);
    @(posedge core_clk);
    ev_q         <= m;
    frame_notify <= nt;
    lst          <= l;
    @(posedge core_clk);
    ev_q <= '0;
  endtask : ev

  task expect_block(input logic [15:0] w, input logic [31:0] p);
    do begin
      @(posedge core_clk);
    end while (host_irq !== 1'h1);
    check("code", 32'(blk_q[0]), 32'(tcs_pkg::CMD_CODE));
    check("word", 32'(blk_q[1]), 32'(w));
    check("ptr", {blk_q[2], blk_q[3]}, p);
    check("rsvd", 32'(blk_q[1] & 16'h80F8), 32'h0);
    check("base", base_q, BASE_V);
  endtask : expect_block

  task set_fields(input int k);
    tcs_fld_t f;
    f = '0;
    f.rlen = 16'($urandom_range(0, 18));
    f.len  = 16'h000F + f.rlen + 16'($urandom_range(1, 60));
    f.sum  = f.len;
    f.bufs = 8'($urandom_range(1, 6));
    f.pri  = 3'($urandom_range(0, 4));
    f.mac  = 1'($urandom);
    f.cls  = 4'h3;
    f.attn = 4'($urandom_range(0, 1));
    f.fc   = {7'($urandom), 1'h0};
    case (k)
      0: f.sum = f.len + 16'h0001;
      1: f.bufs = 8'h07;
      2: f.odd = 1'h1;
      3: f.sbad = 1'h1;
      4: f.pri = 3'h5;
      5: {f.mac, f.cls} = 5'h10;
      6: f.fc[0] = 1'h1;
      7: {f.len, f.sum} = '0;
      8: {f.mac, f.attn} = 5'h12;
      9: {f.mac, f.cls} = 5'h15;
      10: {f.len, f.sum} = {2{16'h000E + f.rlen}};
      11: {f.len, f.sum} = {2{16'h000F + f.rlen}};
      default: ;
    endcase
    fld <= f;
  endtask : set_fields

  function automatic logic [15:0] exp_word();
    logic [15:0] w;
    w     = 16'h0000;
    w[8]  = fld.len != fld.sum || fld.len == 16'h0000 || fld.len < 16'h000F + fld.rlen;
    w[9]  = fld.bufs > CFG_V[7:0];
    w[10] = fld.odd;
    w[11] = fld.sbad;
    w[12] = fld.pri > CFG_V[10:8];
    w[13] = fld.mac && (!CFG_V[16 + fld.cls] || fld.cls == 4'h0 || fld.attn > 4'h1);
    w[14] = fld.fc[0];
    w[2]  = |w[13:8];
    return w;
  endfunction : exp_word

  initial begin
    logic [31:0] l;
    logic [15:0] w;
    core_clk = 1'h0;
    sys_rst  = 1'h1;
    {wb_cyc_i, wb_stb_i, wb_we_i, frame_notify, slow} = '0;
    {wb_adr_i, wb_sel_i, ev_q, wb_dat_i, lst, fld} = '0;
    void'($urandom(32'hC5B6));
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'h0;
    check("idle", {mem_req, host_irq, tx_enable, keep_ctrl_word, wb_ack_o}, 32'h0);
    wb(1'h0, tcs_pkg::REG_CFG, 4'hF, '0);
    check("cfg_rst", rd, tcs_pkg::CFG_RST);
    wb(1'h1, tcs_pkg::REG_CFG, 4'h1, '1);
    wb(1'h0, tcs_pkg::REG_CFG, 4'hF, '0);
    check("cfg_sel", rd, tcs_pkg::CFG_RST);
    wb(1'h1, tcs_pkg::REG_CFG, 4'hF, CFG_V);
    wb(1'h1, tcs_pkg::REG_BASE, 4'hF, BASE_V);
    ev(5'h01, 1'h0, '0);
    ev(5'h08, 1'h0, 32'h0000_2010);
    expect_block(16'h0001, 32'h0000_2010);
    wb(1'h0, tcs_pkg::REG_STAT, 4'hF, '0);
    check("stat", 32'(rd[15:0]), 32'h1);
    check("stat_en", 32'(rd[tcs_pkg::STAT_TXEN]), 32'h0);
    wb(1'h0, tcs_pkg::REG_BASE, 4'hF, '0);
    check("base_rd", rd, BASE_V);
    wb(1'h1, tcs_pkg::REG_PTR, 4'hF, '1);
    wb(1'h0, tcs_pkg::REG_PTR, 4'hF, '0);
    check("ptr_ro", rd, 32'h0000_2010);
    ev(5'h01, 1'h0, '0);
    ev(5'h02, 1'h0, 32'h0000_5550);
    expect_block(16'h0001, 32'h0);
    slow <= 1'h1;
    ev(5'h01, 1'h0, '0);
    ev(5'h04, 1'h1, 32'h0000_3100);
    ev(5'h04, 1'h1, 32'h0000_3200);
    ev(5'h04, 1'h0, 32'h0000_3300);
    expect_block(16'h0002, 32'h0000_3100);
    expect_block(16'h0002, 32'h0000_3300);
    ev(5'h02, 1'h0, '0);
    expect_block(16'h0001, 32'h0000_3300);
    ev(5'h01, 1'h0, '0);
    set_fields(3);
    ev(5'h14, 1'h1, 32'h0000_3400);
    expect_block(16'h0002, 32'h0000_3400);
    expect_block(exp_word(), 32'h0000_3400);
    slow <= 1'h0;
    for (int i = 0; i < 40; i++) begin
      ev(5'h01, 1'h0, '0);
      set_fields(i < 13 ? i : int'($urandom_range(0, 12)));
      l = $urandom & 32'hFFFF_FFFE;
      ev(5'h10, 1'h0, l);
      ev(5'h08, 1'h0, l + 32'h0000_0008);
      w = exp_word();
      if (w != 16'h0000) begin
        expect_block(w, l);
        check("tx_en", 32'(tx_enable), 32'h0);
        check("keep", 32'(keep_ctrl_word), 32'h1);
      end else begin
        expect_block(16'h0001, l + 32'h0000_0008);
        check("keep", 32'(keep_ctrl_word), 32'h0);
      end
    end
    print_verdict();
  end
endmodule : tcs_top_tb
